// ### rtl/dpio_pkg.sv
// Register map, widths and reset values of the dual port I/O block
package dpio_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam logic [ADDR_W-1:0] PORT_A_DATA_OFF = 8'h00;
  localparam logic [ADDR_W-1:0] PORT_E_DATA_OFF = 8'h08;
  localparam logic [ADDR_W-1:0] PORT_E_LED_DRIVE_ENABLE_OFF = 8'h0e;
  localparam logic [ADDR_W-1:0] PORT_A_DIRECTION_REGISTER_OFF = 8'h04;
  localparam logic [ADDR_W-1:0] PORT_E_DIRECTION_REGISTER_OFF = 8'h0c;
  localparam logic [DATA_W-1:0] DIR_RESET = 8'h00;
  localparam logic [DATA_W-1:0] LATCH_RESET = 8'h00;
  localparam logic [DATA_W-1:0] LED_RESET = 8'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;
endpackage

// ### rtl/dpio_top.sv
// Two 8-bit GPIO ports with direction, data latch and port E LED drive
//
// What this block does
// - Port A read returns latch bit where its direction bit is 1.
// - Port A read returns synchronised pin level where direction bit is 0.
// - Port E read returns latch bit where its direction bit is 1.
// - Port E read returns synchronised pin level where direction bit is 0.
// - Data writes always load the latch; input pins still read the pin.
// - Direction 0 releases the pin; direction 1 drives the latch value.
// - Both direction registers are readable and writable at all times.
// - Port E LED enable bit 1 selects high-current sink drive, else standard.
// - LED enable register is 8-bit read/write, cleared to zero on reset.
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
module dpio_top (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Register port
  input wire logic [dpio_pkg::ADDR_W-1:0] i_addr,
  input wire logic [dpio_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [dpio_pkg::DATA_W-1:0] o_rdata,
  // Port A pins
  input wire logic [dpio_pkg::DATA_W-1:0] i_port_a_pin,
  output logic [dpio_pkg::DATA_W-1:0] o_port_a_pin,
  output logic [dpio_pkg::DATA_W-1:0] o_port_a_pin_oe,
  // Port E pins
  input wire logic [dpio_pkg::DATA_W-1:0] i_port_e_pin,
  output logic [dpio_pkg::DATA_W-1:0] o_port_e_pin,
  output logic [dpio_pkg::DATA_W-1:0] o_port_e_pin_oe,
  output logic [dpio_pkg::DATA_W-1:0] o_port_e_led_drive
);
  localparam int unsigned W = dpio_pkg::DATA_W;

  logic [W-1:0] port_a_latch_q;
  logic [W-1:0] port_e_latch_q;
  logic [W-1:0] port_a_direction_q;
  logic [W-1:0] port_e_direction_q;
  logic [W-1:0] led_enable_q;
  logic [W-1:0] a_sync1_q;
  logic [W-1:0] a_sync2_q;
  logic [W-1:0] e_sync1_q;
  logic [W-1:0] e_sync2_q;
  logic [W-1:0] rdata_q;
  logic [W-1:0] rdata_d;

  // Per-bit choice between latch and sensed pin level
  function automatic logic [W-1:0] port_view(input logic [W-1:0] dir,
                                             input logic [W-1:0] latch,
                                             input logic [W-1:0] pin);
    port_view = (dir & latch) | (~dir & pin);
  endfunction

  wire sel_a = i_addr == dpio_pkg::PORT_A_DATA_OFF;
  wire sel_e = i_addr == dpio_pkg::PORT_E_DATA_OFF;
  wire sel_led = i_addr == dpio_pkg::PORT_E_LED_DRIVE_ENABLE_OFF;
  wire sel_dir_a = i_addr == dpio_pkg::PORT_A_DIRECTION_REGISTER_OFF;
  wire sel_dir_e = i_addr == dpio_pkg::PORT_E_DIRECTION_REGISTER_OFF;

  wire [W-1:0] port_a_view = port_view(port_a_direction_q, port_a_latch_q, a_sync2_q);
  wire [W-1:0] port_e_view = port_view(port_e_direction_q, port_e_latch_q, e_sync2_q);

  assign rdata_d = !i_rd ? rdata_q :
                   sel_a ? port_a_view :
                   sel_e ? port_e_view :
                   sel_dir_a ? port_a_direction_q :
                   sel_dir_e ? port_e_direction_q :
                   sel_led ? led_enable_q :
                   dpio_pkg::UNMAPPED_READ;

  // Pin synchronisers
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      a_sync1_q <= dpio_pkg::LATCH_RESET;
      a_sync2_q <= dpio_pkg::LATCH_RESET;
      e_sync1_q <= dpio_pkg::LATCH_RESET;
      e_sync2_q <= dpio_pkg::LATCH_RESET;
    end else begin
      a_sync1_q <= i_port_a_pin;
      a_sync2_q <= a_sync1_q;
      e_sync1_q <= i_port_e_pin;
      e_sync2_q <= e_sync1_q;
    end
  end

  // Register writes
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      port_a_latch_q <= dpio_pkg::LATCH_RESET;
      port_e_latch_q <= dpio_pkg::LATCH_RESET;
      port_a_direction_q <= dpio_pkg::DIR_RESET;
      port_e_direction_q <= dpio_pkg::DIR_RESET;
      led_enable_q <= dpio_pkg::LED_RESET;
    end else if (i_wr) begin
      if (sel_a) port_a_latch_q <= i_wdata;
      if (sel_e) port_e_latch_q <= i_wdata;
      if (sel_dir_a) port_a_direction_q <= i_wdata;
      if (sel_dir_e) port_e_direction_q <= i_wdata;
      if (sel_led) led_enable_q <= i_wdata;
    end
  end

  // Read data valid one cycle after the strobe, held until the next read
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= dpio_pkg::UNMAPPED_READ;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign o_rdata = rdata_q;
  assign o_port_a_pin = port_a_latch_q;
  assign o_port_a_pin_oe = port_a_direction_q;
  assign o_port_e_pin = port_e_latch_q;
  assign o_port_e_pin_oe = port_e_direction_q;
  // High-current sink selection; meaningful only on output pins
  assign o_port_e_led_drive = led_enable_q;
endmodule

// ### test/dpio_chk.sv
// Port checker for the dual port I/O block
`timescale 1ns/1ps
module dpio_chk (
  input wire logic i_clock, i_rst_n, i_wr, i_rd,
  input wire logic [7:0] i_addr, i_wdata, o_rdata, o_port_a_pin, o_port_a_pin_oe,
  input wire logic [7:0] o_port_e_pin, o_port_e_pin_oe, o_port_e_led_drive
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  property p_la; i_wr && i_addr == 8'h00 |=> o_port_a_pin == $past(i_wdata); endproperty
  a_la: assert property (p_la) else $error("latch a");
  property p_le; i_wr && i_addr == 8'h08 |=> o_port_e_pin == $past(i_wdata); endproperty
  a_le: assert property (p_le) else $error("latch e");
  property p_da; i_wr && i_addr == 8'h04 |=> o_port_a_pin_oe == $past(i_wdata); endproperty
  a_da: assert property (p_da) else $error("dir a");
  property p_de; i_wr && i_addr == 8'h0c |=> o_port_e_pin_oe == $past(i_wdata); endproperty
  a_de: assert property (p_de) else $error("dir e");
  property p_ld; i_wr && i_addr == 8'h0e |=> o_port_e_led_drive == $past(i_wdata); endproperty
  a_ld: assert property (p_ld) else $error("led");
  property p_ra; i_rd && i_addr == 8'h00 |=>
    (o_rdata & $past(o_port_a_pin_oe)) == ($past(o_port_a_pin) & $past(o_port_a_pin_oe));
  endproperty
  a_ra: assert property (p_ra) else $error("read a");
  property p_re; i_rd && i_addr == 8'h08 |=>
    (o_rdata & $past(o_port_e_pin_oe)) == ($past(o_port_e_pin) & $past(o_port_e_pin_oe));
  endproperty
  a_re: assert property (p_re) else $error("read e");
  property p_rl; i_rd && i_addr == 8'h0e |=> o_rdata == $past(o_port_e_led_drive); endproperty
  a_rl: assert property (p_rl) else $error("read led");
  c_ra: cover property (i_rd && i_addr == 8'h00);
  c_re: cover property (i_rd && i_addr == 8'h08);
  c_ld: cover property (i_wr && i_addr == 8'h0e);
endmodule

// ### test/dpio_top_tb.sv
// Register level test of the dual port I/O block
`timescale 1ns/1ps
module dpio_top_tb;
  logic i_clock = 0, i_rst_n = 0, i_wr = 0, i_rd = 0;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, i_port_a_pin = 8'h3c, i_port_e_pin = 8'hc3;
  logic [7:0] o_rdata, o_port_a_pin, o_port_a_pin_oe, o_port_e_pin, o_port_e_pin_oe;
  logic [7:0] o_port_e_led_drive;
  int errors = 0, n_checks = 0;
  always #25 i_clock = ~i_clock;
  dpio_top u_dpio_top (.*);
  task automatic chk(input logic [7:0] g, e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %0t got %h want %h", $time, g, e);
    end
  endtask
  // Write when w is 1, else read and compare against d
  task automatic acc(input logic w, input logic [7:0] a, d);
    @(posedge i_clock);
    i_wr <= w;
    i_rd <= !w;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 0;
    i_rd <= 0;
    #1 if (!w) chk(o_rdata, d);
  endtask
  task complete_run;
    $display("errors=%0d checks=%0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge i_clock);
    i_rst_n <= 1;
    #1 chk(o_port_a_pin_oe, 8'h00);
    chk(o_port_e_pin_oe, 8'h00);
    acc(0, 8'h04, 8'h00);
    acc(0, 8'h0e, 8'h00);
    acc(1, 8'h00, 8'ha5);
    chk(o_port_a_pin, 8'ha5);
    acc(0, 8'h00, 8'h3c);
    acc(1, 8'h04, 8'hf0);
    acc(0, 8'h04, 8'hf0);
    chk(o_port_a_pin_oe, 8'hf0);
    acc(0, 8'h00, 8'hac);
    acc(1, 8'h0c, 8'h0f);
    acc(1, 8'h08, 8'h5a);
    chk(o_port_e_pin, 8'h5a);
    acc(0, 8'h08, 8'hca);
    acc(1, 8'h0e, 8'h81);
    chk(o_port_e_led_drive, 8'h81);
    acc(0, 8'h0e, 8'h81);
    chk(o_port_e_pin_oe, 8'h0f);
    acc(0, 8'h01, 8'h00);
    complete_run;
  end
endmodule
bind dpio_top dpio_chk u_dpio_chk (.*);
